/* design/pgef_power_good_flags.sv */
// Event flags, power-good combiner and register slave
// Summary of operation
// - Overvoltage shuts everything down, sets flag; clear ignored while it persists
// - Switcher rail valid/invalid edges set per-rail and summary flags, edge-masked
// - Linear rail valid/invalid edges set per-rail and summary flags, edge-masked
// - Power-good drop from active to inactive sets a maskable flag
// - Sync clock appearing or disappearing sets maskable flag with status bit
// - Detector enabled with no clock present also sets the sync flag
// - Load measurement completion sets maskable flag, write one clears
// - Falling-supply lockout resets everything immediately, no flag raised
// - Leaving lockout resets registers, loads settings, sets reset-cause flag
// - Software reset shuts down, restores defaults, restarts, sets reset-cause flag
// - Status reads one when valid; polarity inverts only the pin
// - Per-rail selects choose monitored rails; dual phase drops slave switcher
// - Disabled regulators are excluded from power-good monitoring
// - Optional thermal warning source for power-good
// - Power-good active only if sources valid and overvoltage/shutdown flags clear
// - Window bit: 0 undervoltage only, 1 both limits
// - Configurable pin polarity and push-pull or open-drain drive
// - Mode from programmed setting; 0 means gated operation
// - Gated mode starts with power-good active after configuration
// - Gated mode holds power-good for 800 us after power-up or voltage change
// - Gated mode latches faults and halts monitoring until cleared
// - Host clears faults by writing one; supply cycle clears too
// - Interrupt pin low while any unmasked event flag pends; latched fault flags do not drive it
// - Mode 1 makes power-good follow regulation continuously
`timescale 1ns/1ps
`default_nettype none
`include "pgef_cfg.svh"
module pgef_power_good_flags import pgef_pkg::*; #(
	parameter int GATE_CYCLES = `PGEF_GATE_US * `PGEF_CLK_MHZ
) (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        ov_detect_i,
	input  wire logic        tsd_detect_i,
	input  wire logic        thermal_warn_i,
	input  wire logic        sync_clk_present_i,
	input  wire logic [3:0]  rail_uv_ok_i,
	input  wire logic [3:0]  rail_ov_ok_i,
	input  wire logic [3:0]  rail_enabled_i,
	input  wire logic        dual_phase_i,
	input  wire logic        load_meas_done_i,
	input  wire logic        volt_change_i,
	input  wire logic        otp_mode_i,
	input  wire logic        otp_reset_mask_i,
	output logic             shutdown_o,
	output logic             irq_out_n_o,
	output logic             supply_ok_pin_o,
	output logic             supply_ok_pin_oe_o
);
	localparam int CW = $clog2(GATE_CYCLES + 1);
	localparam logic [CW-1:0] GATE_LOAD = CW'(GATE_CYCLES);
	localparam pgef_sense_t SENSE_IDLE = '{1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 4'hF}; // Rails in range

	logic                   rst_meta_r;
	logic                   rst_n;
	pgef_sense_t            sense_raw;
	pgef_sense_t            sense_m_r;
	pgef_sense_t            sense_r;
	logic                   clk_q_r;
	logic [3:0]             valid;
	logic [3:0]             valid_q_r;
	logic                   init_r;
	logic                   mode_r;
	logic [15:0]            ctrl_r;
	logic [15:0]            mask_r;
	logic [CW-1:0]          gate_cnt_r;
	logic                   busy;
	logic                   gated;
	logic                   pg_r;
	logic                   pg_nxt;
	logic                   pg_now;
	logic [3:0]             sel;
	logic [3:0]             bad_rail;
	logic                   tw_bad;
	logic [4:0]             fault_set;
	logic [`PGEF_NFLAG-1:0] flag_set;
	logic [`PGEF_NFLAG-1:0] flag_clr;
	logic [`PGEF_NFLAG-1:0] flag_keep;
	logic [`PGEF_NFLAG-1:0] flags;
	logic [3:0]             rail_rise;
	logic [3:0]             rail_fall;
	logic                   sw_sum;
	logic                   lin_sum;
	logic                   irq_req;
	pgef_bus_st_t           bus_st_r;
	logic                   wr_go;
	logic [15:0]            wmask;
	logic [15:0]            wdata;
	logic [31:0]            rd_mux;

	// Register hit for a byte offset
	function automatic logic hit(input logic [4:0] adr, input logic [4:0] off);
		hit = (adr[4:2] == off[4:2]);
	endfunction : hit

	// Byte-lane merge of write data into a stored value
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// Reset release through two flops
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// Analog monitor inputs pass two flops; reset to idle levels so no false edge follows
	assign sense_raw = '{ov: ov_detect_i, tsd: tsd_detect_i, twarn: thermal_warn_i,
		clk_present: sync_clk_present_i, uv_ok: rail_uv_ok_i, ov_ok: rail_ov_ok_i};
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sense_m_r <= SENSE_IDLE;
			sense_r   <= SENSE_IDLE;
			clk_q_r   <= 1'b0;
			valid_q_r <= 4'hF;
		end else begin
			sense_m_r <= sense_raw;
			sense_r   <= sense_m_r;
			clk_q_r   <= sense_r.clk_present;
			valid_q_r <= valid;
		end
	end

	// Initialisation pass after lockout release or software reset
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			init_r <= 1'b1;
		end else begin
			init_r <= wr_go & hit(avs_address_i, `PGEF_ADR_RESET)
				& wmask[`PGEF_SWRST_BIT] & wdata[`PGEF_SWRST_BIT];
		end
	end

	// Control and mask registers, defaults restored on every initialisation
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `PGEF_CTRL_RST;
			mask_r <= `PGEF_MASK_RST;
			mode_r <= 1'b0;
		end else if (init_r) begin
			ctrl_r <= `PGEF_CTRL_RST;
			mask_r <= `PGEF_MASK_RST;
			mask_r[`PGEF_F_RST] <= otp_reset_mask_i;
			mode_r <= otp_mode_i;
		end else if (wr_go) begin
			if (hit(avs_address_i, `PGEF_ADR_CTRL)) begin
				ctrl_r <= merge(ctrl_r, wdata, wmask);
			end
			if (hit(avs_address_i, `PGEF_ADR_MASK)) begin
				mask_r <= merge(mask_r, wdata, wmask);
			end
		end
	end

	// Rail checks and selection of monitored sources
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			valid[i] = sense_r.uv_ok[i] & (~ctrl_r[`PGEF_C_WIN + i] | sense_r.ov_ok[i]);
		end
		sel = ctrl_r[3:0] & rail_enabled_i & {2'b11, ~dual_phase_i, 1'b1};
		bad_rail = sel & ~valid;
		tw_bad = ctrl_r[`PGEF_C_TW] & sense_r.twarn;
		pg_now = ~(|bad_rail) & ~tw_bad & ~flags[`PGEF_F_OV] & ~flags[`PGEF_F_TSD];
	end

	// Gate timer reloads on start-up and voltage change
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			gate_cnt_r <= '0;
		end else if (init_r || volt_change_i) begin
			gate_cnt_r <= GATE_LOAD;
		end else if (busy) begin
			gate_cnt_r <= gate_cnt_r - 1'b1;
		end
	end
	assign busy  = (gate_cnt_r != '0);
	assign gated = ~mode_r;

	// Faults latch once the gate window has passed, at any time in continuous mode
	assign fault_set = {tw_bad, bad_rail} & {5{~gated | ~(busy | volt_change_i)}};

	// Next power-good state
	always_comb begin
		if (init_r) begin
			pg_nxt = 1'b1;
		end else if (gated) begin
			if (busy || volt_change_i) begin
				pg_nxt = pg_r;
			end else begin
				pg_nxt = pg_now & ~(|flags[`PGEF_F_FLT +: 5]);
			end
		end else begin
			pg_nxt = pg_now;
		end
	end

	// Power-good state and its pin
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			pg_r               <= 1'b1;
			supply_ok_pin_o    <= 1'b0;
			supply_ok_pin_oe_o <= 1'b0;
		end else begin
			pg_r <= pg_nxt;
			if (ctrl_r[`PGEF_C_OD]) begin
				supply_ok_pin_o    <= 1'b0;
				supply_ok_pin_oe_o <= ~(pg_r ^ ctrl_r[`PGEF_C_POL]);
			end else begin
				supply_ok_pin_o    <= pg_r ^ ctrl_r[`PGEF_C_POL];
				supply_ok_pin_oe_o <= 1'b1;
			end
		end
	end

	// Edge events per rail, edge masks applied at set
	assign rail_rise = valid & ~valid_q_r & ~mask_r[`PGEF_M_RISE +: 4];
	assign rail_fall = ~valid & valid_q_r & ~mask_r[`PGEF_M_FALL +: 4];

	// Flag set, clear and clear-blocking terms
	always_comb begin
		flag_set = '0;
		flag_set[`PGEF_F_OV]   = sense_r.ov;
		flag_set[`PGEF_F_TSD]  = sense_r.tsd;
		flag_set[`PGEF_F_DROP] = pg_r & ~pg_nxt;
		flag_set[`PGEF_F_SYNC] = (sense_r.clk_present ^ clk_q_r)
			| (ctrl_r[`PGEF_C_DET] & ~sense_r.clk_present);
		flag_set[`PGEF_F_MEAS] = load_meas_done_i;
		flag_set[`PGEF_F_RST]  = init_r;
		flag_set[`PGEF_F_RAIL +: 4] = rail_rise | rail_fall;
		flag_set[`PGEF_F_FLT +: 5]  = fault_set;
		flag_keep = '0;
		flag_keep[`PGEF_F_OV]  = sense_r.ov;
		flag_keep[`PGEF_F_TSD] = sense_r.tsd;
		flag_clr = {`PGEF_NFLAG{init_r}};
		if (wr_go) begin
			if (hit(avs_address_i, `PGEF_ADR_FLAGS)) begin
				flag_clr[5:0] = flag_clr[5:0] | (wdata[5:0] & wmask[5:0]);
			end
			if (hit(avs_address_i, `PGEF_ADR_RAILF)) begin
				flag_clr[9:6] = flag_clr[9:6] | (wdata[3:0] & wmask[3:0]);
			end
			if (hit(avs_address_i, `PGEF_ADR_FAULT)) begin
				flag_clr[14:10] = flag_clr[14:10] | (wdata[4:0] & wmask[4:0]);
			end
		end
	end

	pgef_flag_cell #(
		.W (`PGEF_NFLAG)
	) u_flags (
		.clock_i (clock_i),
		.rst_n_i (rst_n),
		.set_i   (flag_set),
		.clr_i   (flag_clr),
		.keep_i  (flag_keep),
		.flag_o  (flags)
	);

	assign sw_sum  = |flags[`PGEF_F_RAIL +: 2];
	assign lin_sum = |flags[`PGEF_F_RAIL + 2 +: 2];

	// Masked flags combine into the interrupt request
	assign irq_req = flags[`PGEF_F_OV] | flags[`PGEF_F_TSD]
		| (|(flags[`PGEF_F_DROP +: 4] & ~mask_r[`PGEF_F_DROP +: 4]))
		| (|flags[`PGEF_F_RAIL +: 4]);

	// Interrupt pin and shutdown request
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_out_n_o <= 1'b1;
			shutdown_o  <= 1'b1;
		end else begin
			irq_out_n_o <= ~irq_req;
			shutdown_o  <= init_r | sense_r.ov | flags[`PGEF_F_OV]
				| sense_r.tsd | flags[`PGEF_F_TSD];
		end
	end

	// Bus handshake: one wait cycle, then the access completes
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			bus_st_r <= PGEF_BUS_IDLE;
		end else begin
			case (bus_st_r)
				PGEF_BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_st_r <= PGEF_BUS_DONE;
					end
				end
				PGEF_BUS_DONE: begin
					bus_st_r <= PGEF_BUS_IDLE;
				end
				default: begin
					bus_st_r <= PGEF_BUS_IDLE;
				end
			endcase
		end
	end
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (bus_st_r != PGEF_BUS_DONE);
	assign wr_go = (bus_st_r == PGEF_BUS_DONE) & avs_write_i;
	assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign wdata = avs_writedata_i[15:0];

	// Read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i[4:2])
			3'(`PGEF_ADR_FLAGS >> 2): rd_mux[7:0] = {lin_sum, sw_sum, flags[5:0]};
			3'(`PGEF_ADR_RAILF >> 2): rd_mux[3:0] = flags[`PGEF_F_RAIL +: 4];
			3'(`PGEF_ADR_MASK >> 2): rd_mux[15:0] = mask_r;
			3'(`PGEF_ADR_STAT >> 2): rd_mux[11:0] = {valid, 3'h0, sense_r.twarn,
				sense_r.clk_present, pg_r, sense_r.tsd, sense_r.ov};
			3'(`PGEF_ADR_CTRL >> 2): rd_mux[15:0] = {ctrl_r[15], mode_r, ctrl_r[13:0]};
			3'(`PGEF_ADR_FAULT >> 2): rd_mux[4:0] = flags[`PGEF_F_FLT +: 5];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data captured in the wait cycle, when the read is first presented
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (bus_st_r == PGEF_BUS_IDLE && avs_read_i) begin
			avs_readdata_o <= rd_mux;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n);

	a_ov_flag_set: assert property (sense_r.ov |=> flags[`PGEF_F_OV] && shutdown_o)
		else $error("overvoltage did not set flag and shutdown");
	a_ov_no_clear: assert property (sense_r.ov ##1 sense_r.ov |=> flags[`PGEF_F_OV])
		else $error("overvoltage flag cleared while overvoltage persists");
	a_drop_flag: assert property ($fell(pg_r) |-> flags[`PGEF_F_DROP])
		else $error("power-good drop did not set flag");
	a_sync_absent: assert property (ctrl_r[`PGEF_C_DET] && !sense_r.clk_present
		|=> flags[`PGEF_F_SYNC])
		else $error("missing clock did not raise sync flag");
	a_meas_flag: assert property (load_meas_done_i |=> flags[`PGEF_F_MEAS])
		else $error("measurement done not flagged");
	a_reset_cause: assert property (init_r |=> flags[`PGEF_F_RST] && pg_r)
		else $error("initialisation did not set reset cause or power-good");
	a_gate_hold: assert property (gated && volt_change_i && !init_r
		|=> $stable(pg_r) [*8])
		else $error("power-good changed inside gate window");
	a_fault_halts: assert property (gated && !busy && !init_r
		&& (|flags[`PGEF_F_FLT +: 5]) |=> !pg_r)
		else $error("power-good active with fault pending");
	a_cont_ov_low: assert property (!gated && flags[`PGEF_F_OV] && !init_r
		|=> !pg_r)
		else $error("power-good active with overvoltage flag");
	a_irq_level: assert property (irq_req |=> !irq_out_n_o)
		else $error("interrupt pin not low with pending flag");
	a_pin_polarity: assert property (##1 !ctrl_r[`PGEF_C_OD] && $stable(ctrl_r) && $past(rst_n)
		|-> supply_ok_pin_o == ($past(pg_r) ^ ctrl_r[`PGEF_C_POL]))
		else $error("pin polarity wrong");

	c_ov_event: cover property (sense_r.ov ##1 flags[`PGEF_F_OV]);
	c_pg_drop: cover property ($fell(pg_r));
	c_soft_reset: cover property (!init_r ##1 init_r);
	c_bus_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule : pgef_power_good_flags
`default_nettype wire

/* design/pgef_cfg.svh */
// Offsets, field positions, reset values and timing for the power-good flag block
`ifndef PGEF_CFG_SVH
`define PGEF_CFG_SVH
// Register byte offsets
`define PGEF_ADR_FLAGS 5'h00
`define PGEF_ADR_RAILF 5'h04
`define PGEF_ADR_MASK  5'h08
`define PGEF_ADR_STAT  5'h0C
`define PGEF_ADR_CTRL  5'h10
`define PGEF_ADR_FAULT 5'h14
`define PGEF_ADR_RESET 5'h18
// Positions inside the internal flag vector
`define PGEF_F_OV   0
`define PGEF_F_TSD  1
`define PGEF_F_DROP 2
`define PGEF_F_SYNC 3
`define PGEF_F_MEAS 4
`define PGEF_F_RST  5
`define PGEF_F_RAIL 6
`define PGEF_F_FLT  10
`define PGEF_NFLAG  15
// Control register fields
`define PGEF_C_TW   4
`define PGEF_C_WIN  8
`define PGEF_C_POL  12
`define PGEF_C_OD   13
`define PGEF_C_MODE 14
`define PGEF_C_DET  15
// Mask register fields and software reset bit
`define PGEF_M_RISE 8
`define PGEF_M_FALL 12
`define PGEF_SWRST_BIT 0
// Reset values
`define PGEF_CTRL_RST 16'h000F
`define PGEF_MASK_RST 16'h0000
// Gated-mode hold time
`define PGEF_GATE_US 800
`define PGEF_CLK_MHZ 100
`endif

/* design/pgef_pkg.sv */
// Types shared by the power-good flag block
package pgef_pkg;
	// Monitor inputs from the analog side, synchronised as one group
	typedef struct packed {
		logic       ov;
		logic       tsd;
		logic       twarn;
		logic       clk_present;
		logic [3:0] uv_ok;
		logic [3:0] ov_ok;
	} pgef_sense_t;
	// Register bus handshake states
	typedef enum logic [1:0] {
		PGEF_BUS_IDLE = 2'b01,
		PGEF_BUS_DONE = 2'b10
	} pgef_bus_st_t;
endpackage : pgef_pkg

/* design/pgef_flag_cell.sv */
// Sticky event flags with clear and clear-blocking
`timescale 1ns/1ps
`default_nettype none
module pgef_flag_cell #(
	parameter int W = 1
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	input  wire logic [W-1:0] keep_i,
	output logic      [W-1:0] flag_o
);
	genvar g;
	// One flop per flag; set wins over clear, keep blocks the clear
	generate
		for (g = 0; g < W; g++) begin : g_flag
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					flag_o[g] <= 1'b0;
				end else begin
					flag_o[g] <= set_i[g] | (flag_o[g] & ~(clr_i[g] & ~keep_i[g]));
				end
			end
		end
	endgenerate
endmodule : pgef_flag_cell
`default_nettype wire

/* dv/pgef_host_model.sv */
// Host processor view of the power-good pin and the interrupt line
`timescale 1ns/1ps
`default_nettype none
module pgef_host_model (
	input  wire logic       clock_i,
	input  wire logic       irq_out_n_i,
	input  wire logic       pin_i,
	input  wire logic       pin_oe_i,
	output logic            pin_level_o,
	output logic      [7:0] irq_count_o
);
	logic       irq_last_r = 1'b1;
	logic [7:0] irq_cnt_r  = 8'h00;

	// Board pull-up holds the wire high whenever the device releases it
	assign pin_level_o = pin_oe_i ? pin_i : 1'b1;
	assign irq_count_o = irq_cnt_r;

	// Host counts each new interrupt request it sees
	always @(posedge clock_i) begin
		if (irq_last_r && !irq_out_n_i) begin
			irq_cnt_r <= irq_cnt_r + 8'h01;
		end
		irq_last_r <= irq_out_n_i;
	end
endmodule : pgef_host_model
`default_nettype wire

/* dv/test_power_good_and_event_flags.sv */
// Self-checking bench for the power-good and event flag block
`timescale 1ns/1ps
`default_nettype none
`include "pgef_cfg.svh"
module test_power_good_and_event_flags;
	localparam logic [4:0] FL = `PGEF_ADR_FLAGS;
	localparam logic [4:0] RF = `PGEF_ADR_RAILF;
	localparam logic [4:0] MK = `PGEF_ADR_MASK;
	localparam logic [4:0] ST = `PGEF_ADR_STAT;
	localparam logic [4:0] CT = `PGEF_ADR_CTRL;
	localparam logic [4:0] FT = `PGEF_ADR_FAULT;
	localparam logic [4:0] RS = `PGEF_ADR_RESET;
	logic             clock_i   = 1'b0;
	logic             rstn_i    = 1'b0;
	logic [4:0]       adr       = 5'h00;
	logic             rd        = 1'b0;
	logic             wr        = 1'b0;
	logic [31:0]      wdata     = 32'h0000_0000;
	logic             ov        = 1'b0;
	logic             tw        = 1'b0;
	logic             clkp      = 1'b0;
	logic [3:0]       uv        = 4'hF;
	logic [3:0]       ovk       = 4'hF;
	logic [3:0]       en        = 4'hF;
	logic             meas      = 1'b0;
	logic             vchg      = 1'b0;
	logic             dual      = 1'b0;
	logic             mode      = 1'b0;
	logic [31:0]      seed      = 32'h72A2;
	logic [7:0]       c0;
	int               bad_count = 0;
	int               checked   = 0;
	wire logic [31:0] rdata;
	wire logic        wreq, shut, irq_n, pin, pin_oe, level;
	wire logic [7:0]  irq_cnt;

	// Device under test with a short gate window
	pgef_power_good_flags #(.GATE_CYCLES(50)) u_dut (
		.clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .ov_detect_i(ov),
		.tsd_detect_i(1'b0), .thermal_warn_i(tw), .sync_clk_present_i(clkp),
		.rail_uv_ok_i(uv), .rail_ov_ok_i(ovk), .rail_enabled_i(en), .dual_phase_i(dual),
		.load_meas_done_i(meas), .volt_change_i(vchg), .otp_mode_i(mode),
		.otp_reset_mask_i(1'b0), .shutdown_o(shut), .irq_out_n_o(irq_n),
		.supply_ok_pin_o(pin), .supply_ok_pin_oe_o(pin_oe));

	// Far-side host watching the pins
	pgef_host_model u_host (.clock_i(clock_i), .irq_out_n_i(irq_n), .pin_i(pin),
		.pin_oe_i(pin_oe), .pin_level_o(level), .irq_count_o(irq_cnt));

	// 100 MHz clock
	always #5 clock_i = ~clock_i;

	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q);
		adr <= a;
		rd <= !w;
		wr <= w;
		wdata <= {16'h0000, d};
		do begin
			@(posedge clock_i);
		end while (wreq !== 1'b0);
		q = rdata[15:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clock_i);
	endtask : bus

	task automatic wrt(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, a, d, q);
	endtask : wrt

	task automatic rdm(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] q;
		bus(1'b0, a, 16'h0000, q);
		chk(q & m, e);
	endtask : rdm

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc

	task automatic clr;
		wrt(FL, 16'h003F);
		wrt(RF, 16'h000F);
		wrt(FT, 16'h001F);
	endtask : clr

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Rail flag or fault bit expected for rail r unless its edge is masked
	function automatic logic [15:0] exp_bit(input int r, input logic m);
		return m ? 16'h0000 : (16'h0001 << r);
	endfunction : exp_bit

	// Drop flag always, summary flag of the rail's class unless masked
	function automatic logic [15:0] exp_flags(input int r, input logic m);
		return 16'h0004 | (m ? 16'h0000 : (r < 2 ? 16'h0040 : 16'h0080));
	endfunction : exp_flags

	// Watchdog against a hung handshake
	initial begin
		cyc(20000);
		bad_count++;
		test_done;
	end

	// Main sequence
	initial begin
		cyc(20);
		rstn_i <= 1'b1;
		cyc(6);
		rdm(FL, 16'h0020, 16'h0020);
		chk(16'(irq_n), 16'h0000);
		rdm(CT, 16'hFFFF, 16'h000F);
		rdm(MK, 16'hFFFF, 16'h0000);
		rdm(5'h1C, 16'hFFFF, 16'h0000);
		rdm(RS, 16'hFFFF, 16'h0000);
		clr();
		cyc(3);
		rdm(FL, 16'h00FF, 16'h0000);
		chk(16'(irq_n), 16'h0001);
		cyc(60);
		rdm(ST, 16'h0004, 16'h0004);
		chk(16'(level), 16'h0001);
		// Measurement flag, then masked
		c0 = irq_cnt;
		meas <= 1'b1;
		@(posedge clock_i);
		meas <= 1'b0;
		cyc(3);
		rdm(FL, 16'h0010, 16'h0010);
		chk(16'(irq_cnt), 16'(c0 + 8'h01));
		wrt(MK, 16'h0010);
		cyc(2);
		chk(16'(irq_n), 16'h0001);
		rdm(FL, 16'h0010, 16'h0010);
		wrt(FL, 16'h0010);
		wrt(MK, 16'h0000);
		rdm(FL, 16'h0010, 16'h0000);
		// Each rail drops, fall mask chosen at random
		for (int r = 0; r < 4; r++) begin
			seed = lfsr(seed);
			wrt(MK, seed[0] ? (16'h1000 << r) : 16'h0000);
			uv[r] <= 1'b0;
			cyc(6);
			rdm(RF, 16'h000F, exp_bit(r, seed[0]));
			rdm(FL, 16'h00C4, exp_flags(r, seed[0]));
			rdm(FT, 16'h001F, exp_bit(r, 1'b0));
			rdm(ST, 16'h0004, 16'h0000);
			chk(16'(level), 16'h0000);
			uv[r] <= 1'b1;
			cyc(6);
			rdm(ST, 16'h0004, 16'h0000);
			wrt(FT, exp_bit(r, 1'b0));
			cyc(4);
			rdm(ST, 16'h0004, 16'h0004);
			wrt(MK, 16'h0000);
			clr();
		end
		// Overvoltage limit counts only with the window bit set
		ovk[0] <= 1'b0;
		cyc(6);
		rdm(ST, 16'h0004, 16'h0004);
		wrt(CT, 16'h010F);
		cyc(4);
		rdm(ST, 16'h0004, 16'h0000);
		rdm(FT, 16'h001F, 16'h0001);
		ovk[0] <= 1'b1;
		wrt(CT, 16'h000F);
		cyc(4);
		clr();
		cyc(3);
		rdm(ST, 16'h0004, 16'h0004);
		// Disabled or deselected rails never pull the indication down
		en[1] <= 1'b0;
		cyc(2);
		uv[1] <= 1'b0;
		cyc(6);
		rdm(ST, 16'h0004, 16'h0004);
		uv[1] <= 1'b1;
		cyc(4);
		en[1] <= 1'b1;
		wrt(CT, 16'h000E);
		uv[0] <= 1'b0;
		cyc(6);
		rdm(ST, 16'h0004, 16'h0004);
		uv[0] <= 1'b1;
		cyc(4);
		wrt(CT, 16'h000F);
		clr();
		// Thermal warning only when selected
		tw <= 1'b1;
		cyc(6);
		rdm(ST, 16'h0004, 16'h0004);
		wrt(CT, 16'h001F);
		cyc(3);
		rdm(ST, 16'h0004, 16'h0000);
		tw <= 1'b0;
		wrt(CT, 16'h000F);
		cyc(4);
		clr();
		// Voltage change restarts the hold window
		vchg <= 1'b1;
		@(posedge clock_i);
		vchg <= 1'b0;
		uv[2] <= 1'b0;
		cyc(10);
		rdm(ST, 16'h0004, 16'h0004);
		cyc(50);
		rdm(ST, 16'h0004, 16'h0000);
		uv[2] <= 1'b1;
		cyc(4);
		clr();
		// Overvoltage shuts down and blocks its own clear
		ov <= 1'b1;
		cyc(5);
		chk(16'(shut), 16'h0001);
		rdm(FL, 16'h0001, 16'h0001);
		wrt(FL, 16'h0001);
		rdm(FL, 16'h0001, 16'h0001);
		rdm(ST, 16'h0004, 16'h0000);
		ov <= 1'b0;
		cyc(4);
		clr();
		cyc(3);
		rdm(FL, 16'h0001, 16'h0000);
		chk(16'(shut), 16'h0000);
		rdm(ST, 16'h0004, 16'h0004);
		// Every polarity and drive combination
		for (int k = 0; k < 4; k++) begin
			wrt(CT, 16'h000F | (16'(k) << 12));
			cyc(3);
			chk(16'(level), 16'(!k[0]));
			chk(16'(pin_oe), k[1] ? 16'(k[0]) : 16'h0001);
			rdm(ST, 16'h0004, 16'h0004);
		end
		wrt(CT, 16'h000F);
		// External clock edges and detector without clock
		clkp <= 1'b1;
		cyc(6);
		rdm(FL, 16'h0008, 16'h0008);
		rdm(ST, 16'h0008, 16'h0008);
		wrt(FL, 16'h0008);
		clkp <= 1'b0;
		cyc(6);
		rdm(FL, 16'h0008, 16'h0008);
		wrt(CT, 16'h800F);
		wrt(FL, 16'h0008);
		rdm(FL, 16'h0008, 16'h0008);
		wrt(CT, 16'h000F);
		wrt(FL, 16'h0008);
		rdm(FL, 16'h0008, 16'h0000);
		// Software reset restores defaults
		wrt(MK, 16'h0010);
		wrt(RS, 16'h0001);
		cyc(4);
		rdm(MK, 16'hFFFF, 16'h0000);
		rdm(FL, 16'h0020, 16'h0020);
		// Supply lockout in mid-run
		rstn_i <= 1'b0;
		mode <= 1'b1;
		cyc(2);
		chk(16'(irq_n), 16'h0001);
		chk(16'(shut), 16'h0001);
		rstn_i <= 1'b1;
		cyc(6);
		rdm(FL, 16'h0020, 16'h0020);
		// Continuous mode follows the rails at once, inside the hold time too
		rdm(CT, 16'h4000, 16'h4000);
		uv[3] <= 1'b0;
		cyc(6);
		rdm(ST, 16'h0004, 16'h0000);
		uv[3] <= 1'b1;
		cyc(6);
		rdm(ST, 16'h0004, 16'h0004);
		rdm(FT, 16'h001F, 16'h0008);
		// Dual phase drops the second switcher from monitoring
		dual <= 1'b1;
		uv[1] <= 1'b0;
		cyc(6);
		rdm(ST, 16'h0004, 16'h0004);
		uv[1] <= 1'b1;
		cyc(4);
		dual <= 1'b0;
		// Overvoltage flag holds the indication low in continuous mode
		ov <= 1'b1;
		cyc(5);
		rdm(ST, 16'h0004, 16'h0000);
		ov <= 1'b0;
		cyc(4);
		clr();
		cyc(3);
		rdm(ST, 16'h0004, 16'h0004);
		test_done;
	end
endmodule : test_power_good_and_event_flags
`default_nettype wire
